// ==== logic/synth_function_latch_ctrl.sv ====
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module synth_function_latch_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [1:0] addr,
    input wire logic [fnlatch_pkg::WORD_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [fnlatch_pkg::WORD_W-1:0] rdata,
    // device pins and events
    input wire logic chip_enable,
    input wire logic pump_event,
    // controls to the analog and counter blocks
    output fnlatch_pkg::analog_ctrl_t ctrl,
    output logic pump_gain
);
    import fnlatch_pkg::*;

    func_word_t latch_q; // live function latch
    pd_state_t pd_q, pd_d;
    logic gain_q, gain_d; // pump-gain bit of divider latch
    logic [3:0] steps_q; // remaining timer steps
    logic [7:0] sub_q; // events within a step
    logic [WORD_W-1:0] rdata_q;

    // decode: only words whose control bits read hi=1 lo=0 land here
    wire func_wr = wr && addr == ADDR_LATCH &&
        wdata[POS_SEL+1:POS_SEL] == SEL_FUNCTION;
    wire gain_wr = wr && addr == ADDR_GAIN;
    wire func_word_t new_word = func_word_t'(wdata);
    wire func_word_t eff = func_wr ? new_word : latch_q;

    // fastlock mode resolution
    wire fl_on = latch_q.fast_settle_enable;
    wire fl_timed = fl_on && latch_q.fast_settle_mode;
    wire timeout = fl_timed && gain_q && steps_q == 4'h0 &&
        sub_q == 8'h00;

    // the whole word is captured in one edge; the serial register
    // keeps loading even while powered down, so no pd gating here
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_q <= func_word_t'(LATCH_RESET);
        end else if (func_wr) begin
            latch_q <= new_word;
        end
    end

    // power-down sequencing
    always_comb begin
        pd_d = pd_q;
        unique case (pd_q)
            PD_RUN: begin
                if (eff.powerdown_request_bit) begin
                    pd_d = eff.powerdown_sync_select ? PD_WAIT
                                                     : PD_DOWN;
                end
            end
            PD_WAIT: begin
                if (!eff.powerdown_request_bit) begin
                    pd_d = PD_RUN;
                end else if (!eff.powerdown_sync_select) begin
                    pd_d = PD_DOWN;
                end else if (pump_event) begin
                    pd_d = PD_DOWN;
                end
            end
            PD_DOWN: begin
                if (!eff.powerdown_request_bit) begin
                    pd_d = PD_RUN;
                end
            end
            default: pd_d = PD_RUN;
        endcase
    end

    // programmable modes only apply while chip enable is high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pd_q <= PD_RUN;
        end else if (!chip_enable) begin
            pd_q <= PD_RUN;
        end else begin
            pd_q <= pd_d;
        end
    end

    // pin power-down is combinational so it acts at once
    wire powered_down = !chip_enable || pd_q == PD_DOWN;

    // pump gain: host write, auto clear on timeout; host write wins
    always_comb begin
        gain_d = gain_q;
        if (gain_wr) begin
            gain_d = wdata[0];
        end else if (timeout) begin
            gain_d = 1'b0;
        end
    end

    // timeout counter: loaded on gain set, held at load in power-down
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gain_q <= 1'b0;
            steps_q <= 4'h0;
            sub_q <= 8'h00;
        end else begin
            gain_q <= gain_d;
            if (powered_down || (gain_wr && wdata[0]) || !gain_q) begin
                steps_q <= latch_q.settle_timer;
                sub_q <= TIMER_STEP_EVENTS - 8'h01;
            end else if (fl_timed && pump_event && !timeout) begin
                if (sub_q == 8'h00) begin
                    sub_q <= TIMER_STEP_EVENTS - 8'h01;
                    steps_q <= steps_q - 4'h1;
                end else begin
                    sub_q <= sub_q - 8'h01;
                end
            end
        end
    end

    // holding reference and main counters together releases them on
    // the same edge, which gives the aligned restart
    wire hold = latch_q.divider_hold_bit || powered_down;

    // output controls
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= '{default: 1'b0};
        end else begin
            ctrl.counters_hold <= hold;
            ctrl.pump_hiz <= powered_down ||
                latch_q.pump_output_hiz_bit;
            ctrl.lock_detect_clear <= powered_down;
            ctrl.buffers_off <= powered_down;
            ctrl.pump_current <= (fl_on && gain_q) ?
                latch_q.pump_current_second :
                latch_q.pump_current_first;
            ctrl.prescale_sel <= latch_q.prescale_sel;
            ctrl.detector_polarity <= latch_q.detector_polarity_bit;
            ctrl.monitor_select <= latch_q.monitor_select;
        end
    end

    assign pump_gain = gain_q;

    // readback: status word; latch itself is write only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (rd && addr == ADDR_STATUS) begin
            rdata_q <= {19'h0, powered_down, pd_q, gain_q};
        end else begin
            rdata_q <= '0;
        end
    end
    assign rdata = rdata_q;
endmodule
`default_nettype wire

// ==== logic/fnlatch_pkg.sv ====
package fnlatch_pkg;
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_FUNCTION = 2'h2; // hi=1, lo=0
    localparam logic [1:0] ADDR_LATCH = 2'h0; // word port
    localparam logic [1:0] ADDR_STATUS = 2'h1; // state readback
    localparam logic [1:0] ADDR_GAIN = 2'h2; // divider-latch gain bit
    localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
    localparam int POS_SEL = 0;
    localparam int POS_HOLD = 2;
    localparam int POS_PDREQ = 3;
    localparam int POS_MON = 4;
    localparam int POS_POL = 7;
    localparam int POS_HIZ = 8;
    localparam int POS_FEN = 9;
    localparam int POS_FMODE = 10;
    localparam int POS_TIMER = 11;
    localparam int POS_CUR1 = 15;
    localparam int POS_CUR2 = 18;
    localparam int POS_PDSYNC = 21;
    localparam int POS_PRESC = 22;
    // timeout unit in pump events; each timer step counts this many
    localparam logic [7:0] TIMER_STEP_EVENTS = 8'h04;

    typedef struct packed {
        logic [1:0] prescale_sel;
        logic powerdown_sync_select;
        logic [2:0] pump_current_second;
        logic [2:0] pump_current_first;
        logic [3:0] settle_timer;
        logic fast_settle_mode;
        logic fast_settle_enable;
        logic pump_output_hiz_bit;
        logic detector_polarity_bit;
        logic [2:0] monitor_select;
        logic powerdown_request_bit;
        logic divider_hold_bit;
        logic [1:0] latch_select;
    } func_word_t;

    typedef struct packed {
        logic counters_hold; // reference/main counters held
        logic pump_hiz; // pump output undriven
        logic lock_detect_clear;
        logic buffers_off; // ref buffer off, rf debiased, dc off
        logic [2:0] pump_current; // active current setting
        logic [1:0] prescale_sel;
        logic detector_polarity;
        logic [2:0] monitor_select;
    } analog_ctrl_t;

    typedef enum logic [2:0] {
        PD_RUN = 3'h1,
        PD_WAIT = 3'h2,
        PD_DOWN = 3'h4
    } pd_state_t;
endpackage

// ==== dv/fn_chk_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module fn_chk (
    // watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] addr,
    input wire logic [23:0] wdata,
    input wire logic wr,
    input wire logic chip_enable,
    input wire logic pump_event,
    input wire fnlatch_pkg::analog_ctrl_t ctrl,
    input wire logic pump_gain
);
    import fnlatch_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // accepted latch write; ctrl shows it two edges later
    wire lw = wr && addr == ADDR_LATCH && wdata[1:0] == SEL_FUNCTION;
    chk_hold_set: assert property (
        lw && wdata[2] |-> ##2 ctrl.counters_hold) else $error("hold");
    chk_mon_sel: assert property (
        lw |-> ##2 ctrl.monitor_select == $past(wdata[6:4], 2))
        else $error("monitor");
    chk_presc_pol: assert property (
        lw |-> ##2 {ctrl.prescale_sel, ctrl.detector_polarity} ==
        $past({wdata[23:22], wdata[7]}, 2)) else $error("fields");
    // three samples low so the pin path has passed its one register, ctrl
    chk_ce_off: assert property (
        !chip_enable [*3] |-> ctrl.buffers_off && ctrl.pump_hiz &&
        ctrl.counters_hold && ctrl.lock_detect_clear) else $error("ce");
    chk_async_pd: assert property (
        lw && wdata[3] && !wdata[21] && chip_enable ##1 chip_enable
        |-> ##1 ctrl.pump_hiz && ctrl.buffers_off) else $error("async");
    chk_sync_wait: assert property (
        lw && wdata[3] && wdata[21] && !ctrl.buffers_off
        ##1 (!pump_event && !wr && chip_enable) [*2]
        |-> !ctrl.buffers_off) else $error("sync early");
    chk_gain_set: assert property (
        wr && addr == ADDR_GAIN |-> ##1 pump_gain == $past(wdata[0]))
        else $error("gain");
    chk_hiz_bit: assert property (
        lw && wdata[8] |-> ##2 ctrl.pump_hiz) else $error("hiz");
    cov_async: cover property (lw && wdata[3] && !wdata[21]);
    cov_sync: cover property (lw && wdata[3] && wdata[21]);
    cov_drop: cover property ($fell(pump_gain) && !wr);
endmodule
bind synth_function_latch_ctrl fn_chk fn_chk_i (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .chip_enable(chip_enable),
    .pump_event(pump_event), .ctrl(ctrl), .pump_gain(pump_gain));
`default_nettype wire

// ==== dv/pump_event_src.sv ====
`timescale 1ns/1ns
`default_nettype none
module pump_event_src (
    // clock, reset, gate
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    // one pulse every four cycles while run
    output logic pump_event
);
    logic [1:0] cnt_q; // phase; held when stopped so sync pd stays pending
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 2'h0;
        end else if (run) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    assign pump_event = run && cnt_q == 2'h3;
endmodule
`default_nettype wire

// ==== dv/synth_function_latch_ctrl_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module synth_function_latch_ctrl_tb_top;
    import fnlatch_pkg::*;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, ce = 1'b0;
    logic run = 1'b0, pump_event, pump_gain;
    logic [1:0] addr = 2'h0;
    logic [23:0] wdata = 24'h0, rdata;
    analog_ctrl_t ctrl;
    int miscompares = 0, n_checks = 0;
    always #50 clk = ~clk;
    synth_function_latch_ctrl synth_function_latch_ctrl_i (.clk(clk),
        .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .chip_enable(ce), .pump_event(pump_event),
        .ctrl(ctrl), .pump_gain(pump_gain));
    pump_event_src pump_event_src_i (.clk(clk), .reset(reset), .run(run),
        .pump_event(pump_event));
    task cmp(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one-cycle write, returns once ctrl has settled
    task put(input logic [1:0] a, input logic [23:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // status: {powered_down, pd_state, gain}
    task get(input logic [1:0] a, input logic [23:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp(rdata, e);
    endtask
    // f: hold pdreq hiz fen fmode pdsync; cur 3/6, timer 1, presc 2, pol 1
    function automatic logic [23:0] fw(input logic [5:0] f, logic [2:0] m);
        fw = {2'h2, f[0], 6'h33, 4'h1, f[1], f[2], f[3], 1'h1, m, f[4],
            f[5], 2'h2};
    endfunction
    task wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        ce <= 1'b1;
        run <= 1'b1;
        put(ADDR_LATCH, fw(6'h20, 3'h5));
        cmp(ctrl.counters_hold, 1'h1);
        put(ADDR_LATCH, fw(6'h04, 3'h5));
        cmp({ctrl.counters_hold, ctrl.monitor_select, ctrl.prescale_sel,
            ctrl.pump_current}, {1'h0, 3'h5, 2'h2, 3'h3});
        put(ADDR_LATCH, fw(6'h04, 3'h7) ^ 24'h3);
        cmp(ctrl.monitor_select, 3'h5);
        put(ADDR_GAIN, 24'h1);
        cmp(ctrl.pump_current, 3'h6);
        wait_n(60);
        get(ADDR_STATUS, 24'h3);
        put(ADDR_GAIN, 24'h0);
        cmp(ctrl.pump_current, 3'h3);
        put(ADDR_LATCH, fw(6'h00, 3'h5));
        put(ADDR_GAIN, 24'h1);
        cmp(ctrl.pump_current, 3'h3);
        put(ADDR_LATCH, fw(6'h06, 3'h5));
        cmp(ctrl.pump_current, 3'h6);
        wait_n(18);
        cmp(ctrl.pump_current, 3'h6);
        wait_n(24);
        cmp({pump_gain, ctrl.pump_current}, 4'h3);
        put(ADDR_LATCH, fw(6'h10, 3'h5));
        get(ADDR_STATUS, 24'h18);
        put(ADDR_LATCH, fw(6'h10, 3'h3));
        cmp(ctrl.monitor_select, 3'h3);
        put(ADDR_LATCH, fw(6'h00, 3'h3));
        cmp({ctrl.buffers_off, ctrl.pump_hiz}, 2'h0);
        @(posedge clk);
        run <= 1'b0; // hold back pump events
        put(ADDR_LATCH, fw(6'h11, 3'h3));
        get(ADDR_STATUS, 24'h4);
        @(posedge clk);
        run <= 1'b1;
        wait_n(8);
        get(ADDR_STATUS, 24'h18);
        put(ADDR_LATCH, fw(6'h00, 3'h3));
        @(posedge clk);
        ce <= 1'b0;
        get(ADDR_STATUS, 24'h12);
        @(posedge clk);
        ce <= 1'b1;
        wait_n(3);
        cmp(ctrl.buffers_off, 1'h0);
        put(ADDR_LATCH, fw(6'h08, 3'h3));
        cmp(ctrl.pump_hiz, 1'h1);
        end_of_test();
    end
    // a hang stops the run well past the expected run of under two hundred cycles
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    task end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
